// ### io_cfg_pkg.sv
// Constants shared by the reset I/O configuration block and its ramp unit.
package io_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int VCODE_W = 6;
    localparam int SLEW_W = 3;
    localparam int DIV_W = 20;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CORE_A = 8'h04;
    localparam logic [7:0] OFS_CORE_B = 8'h08;
    localparam logic [7:0] OFS_SLEW = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Control register bit positions.
    localparam int CTRL_PIN_A_USER = 0;
    localparam int CTRL_OUT_USER = 1;
    localparam int CTRL_PIN_C_USER = 2;
    localparam int CTRL_MODE_SEL = 3;
    localparam int CTRL_DRIVE_TYPE = 4;
    localparam int CTRL_CORE_RST_EN = 5;
    localparam int CTRL_W = 6;

    // Status register bit positions.
    localparam int ST_PIN_A_IN = 0;
    localparam int ST_PIN_C_IN = 1;
    localparam int ST_MAIN_POWER_GOOD = 2;
    localparam int ST_HELD_LEVEL = 3;
    localparam int ST_RAMP_A_BUSY = 4;
    localparam int ST_RAMP_B_BUSY = 5;
    localparam int ST_CORE_RST_SEEN = 6;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h07;
    localparam logic [VCODE_W-1:0] CORE_A_RST = 6'h20;
    localparam logic [VCODE_W-1:0] CORE_B_RST = 6'h20;
    localparam logic [SLEW_W-1:0] SLEW_RST = 3'h0;

    // Ramp timing: one code step per interval, doubled per slew setting.
    localparam int CLK_PERIOD_NS = 100;
    localparam int RAMP_STEP_NS = 10000;
    localparam int RAMP_STEP_CYCLES =
        (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### core_ramp.sv
// Steps one core regulator output code toward its target, one code per tick.
module core_ramp
    import io_cfg_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic step_en, // One-cycle pulse per ramp step.
    input wire logic [VCODE_W-1:0] target, // Code to ramp toward.
    input wire logic [VCODE_W-1:0] rst_code, // Unused; reset loads CORE_A_RST.
    output logic [VCODE_W-1:0] code_q, // Present output code.
    output logic busy_q // High while code differs from target.
);
    logic [VCODE_W-1:0] code_d;
    logic busy_d;

    // The rail is never switched off; it only moves one code at a time.
    always_comb begin
        code_d = code_q;
        if (step_en && code_q < target) begin
            code_d = code_q + 6'h01;
        end else if (step_en && code_q > target) begin
            code_d = code_q - 6'h01;
        end
        busy_d = (code_d != target);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= CORE_A_RST;
            busy_q <= 1'b0;
        end else begin
            code_q <= code_d;
            busy_q <= busy_d;
        end
    end

    logic unused_rst_code;
    assign unused_rst_code = ^rst_code;
endmodule

// ### ddr_reset_io_config.sv
// Memory-reset and core-rail-reset pin logic with an APB register file.
//
// Contract
// - With mode select 0 pin A is open drain from its user bit or the sequencer, 0 low and 1 released.
// - With mode select 1 and power-good high, pin A is an input and the reset output copies its level.
// - With mode select 1 and power-good low, the reset output is low after reset, else holds the level caught as power-good fell.
// - With mode select 0 the reset output follows its user bit, open drain for drive type 0 and push-pull for 1.
// - In memory reset mode the reset output is open drain for drive type 0 and push-pull for 1.
// - Mode select 1 makes pin A an input and the reset output an output.
// - With core reset enable 0 pin C is open drain from its user bit or the sequencer, 0 low and 1 released.
// - With core reset enable 1 each falling edge on pin C restores only the two core voltage registers.
// - After a core reset edge both core rails ramp to default at the slew setting without power cycling.
// - Main power-good is low when an enabled main rail is out of tolerance or in suspend.
//
// Design decisions made here: the APB register port and the register offsets.
module ddr_reset_io_config
    import io_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_STEP_CYCLES
) (
    input wire logic core_clk, // System clock, 10 MHz.
    input wire logic rst_n, // Power-on reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic main_power_good, // Main rails good, asynchronous.
    input wire logic seq_pin_a_ctrl, // Sequencer owns pin A.
    input wire logic seq_pin_a_level, // Sequencer level for pin A.
    input wire logic seq_pin_c_ctrl, // Sequencer owns pin C.
    input wire logic seq_pin_c_level, // Sequencer level for pin C.
    input wire logic mem_reset_in_pin_i, // Pin A level.
    output logic mem_reset_in_pin_o, // Pin A drive value.
    output logic mem_reset_in_pin_oe_n, // Pin A enable, low drives.
    output logic mem_reset_out_pin_o, // Reset output drive value.
    output logic mem_reset_out_pin_oe_n, // Reset output enable, low drives.
    input wire logic core_rail_reset_pin_i, // Pin C level.
    output logic core_rail_reset_pin_o, // Pin C drive value.
    output logic core_rail_reset_pin_oe_n, // Pin C enable, low drives.
    output logic [VCODE_W-1:0] core_buck_a_code, // Core rail A code.
    output logic [VCODE_W-1:0] core_buck_b_code // Core rail B code.
);
    localparam int NSYNC = 3;
    // Pins idle high behind pull-ups, while power-good starts out low so
    // that the held reset level cannot catch the pin during reset release.
    localparam logic [NSYNC-1:0] SYNC_RST = 3'h3;

    // Two-stage synchronisers for pin A, pin C and power-good.
    logic [NSYNC-1:0] sync_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign sync_raw = {main_power_good, core_rail_reset_pin_i,
                       mem_reset_in_pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[gi] <= SYNC_RST[gi];
                    sync2_q[gi] <= SYNC_RST[gi];
                end else begin
                    sync1_q[gi] <= sync_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic pin_a_s;
    logic pin_c_s;
    logic main_power_good_s;
    assign pin_a_s = sync2_q[0];
    assign pin_c_s = sync2_q[1];
    assign main_power_good_s = sync2_q[2];

    function automatic logic od_drive_low(input logic own_seq,
                                          input logic seq_lvl,
                                          input logic user_lvl);
        od_drive_low = own_seq ? !seq_lvl : !user_lvl;
    endfunction

    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [VCODE_W-1:0] tgt_a_q, tgt_a_d, tgt_b_q, tgt_b_d;
    logic [SLEW_W-1:0] slew_q, slew_d;
    logic seen_q, seen_d;
    logic held_q, held_d;
    logic pin_c_prev_q, pin_c_prev_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic a_oe_n_q, a_oe_n_d;
    logic b_o_q, b_o_d, b_oe_n_q, b_oe_n_d;
    logic c_oe_n_q, c_oe_n_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic step_q, step_d;
    logic busy_a, busy_b;
    logic [VCODE_W-1:0] code_a, code_b;

    logic wr_fire;
    logic mapped;
    logic core_edge;
    logic mode_sel;
    logic out_level;
    logic [DIV_W-1:0] step_limit;
    logic [31:0] status_word;

    assign mode_sel = ctrl_q[CTRL_MODE_SEL];
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CORE_A) ||
                    (paddr == OFS_CORE_B) || (paddr == OFS_SLEW) ||
                    (paddr == OFS_STATUS);
    // Only a transition counts, so a pin held low never retriggers.
    assign core_edge = ctrl_q[CTRL_CORE_RST_EN] && pin_c_prev_q &&
                       !pin_c_s;
    assign step_limit = DIV_W'(STEP_CYCLES) << slew_q;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_PIN_A_IN] = pin_a_s;
        status_word[ST_PIN_C_IN] = pin_c_s;
        status_word[ST_MAIN_POWER_GOOD] = main_power_good_s;
        status_word[ST_HELD_LEVEL] = held_q;
        status_word[ST_RAMP_A_BUSY] = busy_a;
        status_word[ST_RAMP_B_BUSY] = busy_b;
        status_word[ST_CORE_RST_SEEN] = seen_q;
    end

    // Register file, APB answer and core reset handling.
    always_comb begin
        ctrl_d = ctrl_q;
        tgt_a_d = tgt_a_q;
        tgt_b_d = tgt_b_q;
        slew_d = slew_q;
        seen_d = seen_q;
        pready_d = psel && !penable;
        pslverr_d = psel && !penable && !mapped;
        prdata_d = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CTRL: prdata_d = {26'h0, ctrl_q};
                OFS_CORE_A: prdata_d = {26'h0, tgt_a_q};
                OFS_CORE_B: prdata_d = {26'h0, tgt_b_q};
                OFS_SLEW: prdata_d = {29'h0, slew_q};
                OFS_STATUS: prdata_d = status_word;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_fire) begin
            unique case (paddr)
                OFS_CTRL: ctrl_d = pwdata[CTRL_W-1:0];
                OFS_CORE_A: tgt_a_d = pwdata[VCODE_W-1:0];
                OFS_CORE_B: tgt_b_d = pwdata[VCODE_W-1:0];
                OFS_SLEW: slew_d = pwdata[SLEW_W-1:0];
                OFS_STATUS: begin
                    if (pwdata[ST_CORE_RST_SEEN]) begin
                        seen_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // The pin edge beats a software write in the same cycle.
        if (core_edge) begin
            tgt_a_d = CORE_A_RST;
            tgt_b_d = CORE_B_RST;
            seen_d = 1'b1;
        end
        pin_c_prev_d = pin_c_s;
    end

    // Memory reset level: tracks pin A while power-good is high, else holds.
    always_comb begin
        held_d = held_q;
        if (main_power_good_s) begin
            held_d = pin_a_s;
        end
        out_level = mode_sel ? held_d : ctrl_q[CTRL_OUT_USER];
    end

    // Pin drivers.
    always_comb begin
        if (mode_sel) begin
            a_oe_n_d = 1'b1;
        end else begin
            a_oe_n_d = !od_drive_low(seq_pin_a_ctrl, seq_pin_a_level,
                                     ctrl_q[CTRL_PIN_A_USER]);
        end
        if (ctrl_q[CTRL_DRIVE_TYPE]) begin
            b_o_d = out_level;
            b_oe_n_d = 1'b0;
        end else begin
            b_o_d = 1'b0;
            b_oe_n_d = out_level;
        end
        if (ctrl_q[CTRL_CORE_RST_EN]) begin
            c_oe_n_d = 1'b1;
        end else begin
            c_oe_n_d = !od_drive_low(seq_pin_c_ctrl, seq_pin_c_level,
                                     ctrl_q[CTRL_PIN_C_USER]);
        end
    end

    // Ramp step divider.
    always_comb begin
        div_d = div_q + 20'h00001;
        step_d = 1'b0;
        if (div_q + 20'h00001 >= step_limit) begin
            div_d = 20'h00000;
            step_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            tgt_a_q <= CORE_A_RST;
            tgt_b_q <= CORE_B_RST;
            slew_q <= SLEW_RST;
            seen_q <= 1'b0;
            held_q <= 1'b0;
            pin_c_prev_q <= 1'b1;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            a_oe_n_q <= 1'b1;
            b_o_q <= 1'b0;
            b_oe_n_q <= 1'b1;
            c_oe_n_q <= 1'b1;
            div_q <= 20'h00000;
            step_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            tgt_a_q <= tgt_a_d;
            tgt_b_q <= tgt_b_d;
            slew_q <= slew_d;
            seen_q <= seen_d;
            held_q <= held_d;
            pin_c_prev_q <= pin_c_prev_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            a_oe_n_q <= a_oe_n_d;
            b_o_q <= b_o_d;
            b_oe_n_q <= b_oe_n_d;
            c_oe_n_q <= c_oe_n_d;
            div_q <= div_d;
            step_q <= step_d;
        end
    end

    core_ramp u_ramp_a (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .step_en(step_q),
        .target(tgt_a_q),
        .rst_code(CORE_A_RST),
        .code_q(code_a),
        .busy_q(busy_a)
    );

    core_ramp u_ramp_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .step_en(step_q),
        .target(tgt_b_q),
        .rst_code(CORE_B_RST),
        .code_q(code_b),
        .busy_q(busy_b)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_reset_in_pin_o = 1'b0;
    assign mem_reset_in_pin_oe_n = a_oe_n_q;
    assign mem_reset_out_pin_o = b_o_q;
    assign mem_reset_out_pin_oe_n = b_oe_n_q;
    assign core_rail_reset_pin_o = 1'b0;
    assign core_rail_reset_pin_oe_n = c_oe_n_q;
    assign core_buck_a_code = code_a;
    assign core_buck_b_code = code_b;
endmodule

// ### reset_io_monitor.sv
// Port checker for the reset I/O block, bound to its top module.
module reset_io_monitor
    import io_cfg_pkg::*;
(
    input wire logic core_clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic main_power_good, // Power-good input.
    input wire logic mem_reset_in_pin_i, // Pin A level.
    input wire logic mem_reset_in_pin_o, // Pin A value.
    input wire logic mem_reset_out_pin_o, // Reset output value.
    input wire logic mem_reset_out_pin_oe_n, // Reset output enable.
    input wire logic core_rail_reset_pin_o, // Pin C value.
    input wire logic [VCODE_W-1:0] core_buck_a_code, // Rail A code.
    input wire logic [VCODE_W-1:0] core_buck_b_code // Rail B code.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence quiet_s;
        $stable(mem_reset_in_pin_i) && $stable(main_power_good) && !psel;
    endsequence
    a_setup_ready: assert property (setup_s |=> pready)
        else $error("ready missing after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_pin_a_od: assert property (mem_reset_in_pin_o == 1'b0)
        else $error("pin A driven high");
    a_pin_c_od: assert property (core_rail_reset_pin_o == 1'b0)
        else $error("pin C driven high");
    a_out_drive_form: assert property (
        mem_reset_out_pin_o |-> !mem_reset_out_pin_oe_n)
        else $error("reset output high while released");
    a_out_quiet: assert property (quiet_s [*3] |=>
        $stable(mem_reset_out_pin_o) && $stable(mem_reset_out_pin_oe_n))
        else $error("reset output moved with quiet inputs");
    a_ramp_a_step: assert property ($changed(core_buck_a_code) |->
        core_buck_a_code == $past(core_buck_a_code) + 6'h01 ||
        core_buck_a_code == $past(core_buck_a_code) - 6'h01)
        else $error("rail A code jumped");
    a_ramp_b_step: assert property ($changed(core_buck_b_code) |->
        core_buck_b_code == $past(core_buck_b_code) + 6'h01 ||
        core_buck_b_code == $past(core_buck_b_code) - 6'h01)
        else $error("rail B code jumped");
    a_ramp_a_hold: assert property (
        $changed(core_buck_a_code) |=> $stable(core_buck_a_code))
        else $error("rail A stepped twice in a row");
endmodule
bind ddr_reset_io_config reset_io_monitor u_reset_io_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .main_power_good(main_power_good),
    .mem_reset_in_pin_i(mem_reset_in_pin_i),
    .mem_reset_in_pin_o(mem_reset_in_pin_o),
    .mem_reset_out_pin_o(mem_reset_out_pin_o),
    .mem_reset_out_pin_oe_n(mem_reset_out_pin_oe_n),
    .core_rail_reset_pin_o(core_rail_reset_pin_o),
    .core_buck_a_code(core_buck_a_code), .core_buck_b_code(core_buck_b_code)
);

// ### soc_host_model.sv
// Host-side model of the reset wires, with pull-ups on released pins.
module soc_host_model (
    input wire logic a_drive, // Host drives pin A.
    input wire logic a_level, // Host level for pin A.
    input wire logic c_pull_low, // Host pulls pin C low.
    input wire logic a_oe_n, // Device enable for pin A.
    input wire logic c_oe_n, // Device enable for pin C.
    input wire logic out_o, // Device reset output value.
    input wire logic out_oe_n, // Device reset output enable.
    output logic a_wire, // Resolved pin A.
    output logic c_wire, // Resolved pin C.
    output logic out_wire // Resolved reset output.
);
    timeunit 1ns;
    timeprecision 1ns;
    assign a_wire = !a_oe_n ? 1'b0 : (a_drive ? a_level : 1'b1);
    // Each new pull low is a fresh falling edge; holding it low asks nothing.
    assign c_wire = !c_oe_n ? 1'b0 : !c_pull_low;
    assign out_wire = !out_oe_n ? out_o : 1'b1;
endmodule

// ### ddr_reset_io_config_test.sv
// Self-checking bench for the reset I/O block.
module ddr_reset_io_config_test import io_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, main_power_good = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic seq_a_c = 1'b0, seq_a_l = 1'b0, seq_c_c = 1'b0, seq_c_l = 1'b0;
    logic a_drive = 1'b0, a_level = 1'b1, c_pull_low = 1'b0;
    logic pready, pslverr, a_i, a_o, a_oe_n, out_o, out_oe_n;
    logic c_i, c_o, c_oe_n, out_wire;
    logic [VCODE_W-1:0] code_a, code_b;
    logic [32:0] rd_q[$], exp_q[$];
    int errors = 0, n_checks = 0;
    event note_ev;
    ddr_reset_io_config #(.STEP_CYCLES(2)) u_ddr_reset_io_config (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .main_power_good(main_power_good),
        .seq_pin_a_ctrl(seq_a_c), .seq_pin_a_level(seq_a_l),
        .seq_pin_c_ctrl(seq_c_c), .seq_pin_c_level(seq_c_l),
        .mem_reset_in_pin_i(a_i), .mem_reset_in_pin_o(a_o),
        .mem_reset_in_pin_oe_n(a_oe_n), .mem_reset_out_pin_o(out_o),
        .mem_reset_out_pin_oe_n(out_oe_n), .core_rail_reset_pin_i(c_i),
        .core_rail_reset_pin_o(c_o), .core_rail_reset_pin_oe_n(c_oe_n),
        .core_buck_a_code(code_a), .core_buck_b_code(code_b));
    soc_host_model u_soc_host_model (.a_drive(a_drive), .a_level(a_level),
        .c_pull_low(c_pull_low), .a_oe_n(a_oe_n), .c_oe_n(c_oe_n),
        .out_o(out_o), .out_oe_n(out_oe_n), .a_wire(a_i), .c_wire(c_i),
        .out_wire(out_wire));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic results();
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [32:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle cycle keeps the next setup from driving psel twice at once.
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Pin outputs settle three edges after a cause; four are allowed.
    task automatic note(input logic [32:0] e, input logic codes);
        exp_q.push_back({codes, e[31:0]});
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        -> note_ev;
        @(posedge core_clk);
    endtask
    task automatic wait_codes(input logic [5:0] a, input logic [5:0] b);
        for (int n = 0; n < 800 && {code_a, code_b} !== {a, b}; n++) begin
            @(posedge core_clk);
        end
        note({21'h0, a, b}, 1'b1);
    endtask
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp("apb read", rd_q.pop_front(), {pslverr, prdata});
        end
    end
    always @(note_ev) begin
        logic [32:0] e;
        e = exp_q.pop_front();
        if (e[32]) begin
            cmp("codes", {1'b0, e[31:0]}, {21'h0, code_a, code_b});
        end else begin
            cmp("pins", e, {29'h0, a_oe_n, out_o, out_oe_n, c_oe_n});
        end
    end
    initial begin
        #2000000;
        errors++;
        results();
    end
    initial begin
        logic [5:0] v;
        logic [3:0] r;
        logic ea, ec;
        void'($urandom(32'h27E4));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        note(33'hB, 1'b0);
        rd(OFS_CTRL, 33'h07);
        rd(OFS_CORE_A, 33'h20);
        rd(OFS_CORE_B, 33'h20);
        rd(OFS_SLEW, 33'h0);
        rd(8'h14, 33'h100000000);
        for (int i = 0; i < 16; i++) begin
            v = {1'b0, i[3], 1'b0, i[2:0]};
            r = 4'($urandom);
            seq_a_c <= r[0];
            seq_a_l <= r[1];
            seq_c_c <= r[2];
            seq_c_l <= r[3];
            wr(OFS_CTRL, 32'(v));
            ea = r[0] ? r[1] : v[0];
            ec = r[2] ? r[3] : v[2];
            note({ea, v[4] ? {v[1], 1'b0} : {1'b0, v[1]}, ec},
                 1'b0);
        end
        seq_a_c <= 1'b0;
        seq_c_c <= 1'b0;
        a_drive <= 1'b1;
        wr(OFS_CTRL, 32'h1F);
        note(33'h9, 1'b0);
        main_power_good <= 1'b1;
        note(33'hD, 1'b0);
        a_level <= 1'b0;
        note(33'h9, 1'b0);
        a_level <= 1'b1;
        note(33'hD, 1'b0);
        main_power_good <= 1'b0;
        note(33'hD, 1'b0);
        a_level <= 1'b0;
        note(33'hD, 1'b0);
        wr(OFS_CTRL, 32'h0F);
        note(33'hB, 1'b0);
        main_power_good <= 1'b1;
        note(33'h9, 1'b0);
        wr(OFS_SLEW, 32'h1);
        wr(OFS_CORE_A, 32'h05);
        wr(OFS_CORE_B, 32'h3F);
        wr(OFS_CTRL, 32'h27);
        wait_codes(6'h05, 6'h3F);
        note(33'hB, 1'b0);
        c_pull_low <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(OFS_CORE_A, 33'h20);
        rd(OFS_CORE_B, 33'h20);
        rd(OFS_SLEW, 33'h1);
        rd(OFS_CTRL, 33'h27);
        wait_codes(6'h20, 6'h20);
        wr(OFS_CORE_A, 32'h10);
        repeat (6) @(posedge core_clk);
        rd(OFS_CORE_A, 33'h10);
        c_pull_low <= 1'b0;
        repeat (6) @(posedge core_clk);
        c_pull_low <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(OFS_CORE_A, 33'h20);
        results();
    end
endmodule
